// ===== src/vsp_consts.svh
// vsp_consts.svh: offsets, fields, reset values and timing counts
// Assumes inclusion by bare name from the files that use it; definitions only.
// Operation
// R01: Zero frequency with ramping enabled decelerates, then ends the train.
// R02: Zero frequency with ramping disabled ends the train at once.
// R03: Program restarts only after busy low plus one scan cycle.
// R04: Program must not flip frequency sign during output; stop first.
// R05: Contact released with ramping enabled ramps down, then ends the train.
// R06: Contact released with ramping disabled ends the train at once.
// R07: Stop by contact release leaves the completion flag clear.
// R08: Limit in travel direction stops at once and raises abnormal end.
// R09: While busy, other positioning commands on this channel are refused.
// R10: Program issues no other command while busy after contact release.
// R11: Finishing execution drives the direction line off.
// R12: Ramp enable is one global setting, no per-channel choice.
// R13: Legacy firmware mode never ramps at start or stop.
// R14: Frequency magnitude 1 to 100000 Hz, 200000 with adapter; zero stops.
// R15: Positive means forward, line on, count up; negative the reverse.
// R16: Train comes from dividing the clock; busy spans the whole train.
// R17: Ramping moves linearly between bias and target, capped at maximum.
`ifndef VSP_CONSTS_SVH
`define VSP_CONSTS_SVH

// ==========================================
// Register offsets
`define VSP_OFF_CTRL   8'h00
`define VSP_OFF_FREQ   8'h04
`define VSP_OFF_STAT   8'h08
`define VSP_OFF_ISTAT  8'h0c
`define VSP_OFF_IMASK  8'h10
`define VSP_OFF_BIAS   8'h14
`define VSP_OFF_MAXSPD 8'h18
`define VSP_OFF_STEP   8'h1c
`define VSP_OFF_POS    8'h20
`define VSP_OFF_CMD    8'h24

// ==========================================
// Control fields
`define VSP_CTRL_ACT     0
`define VSP_CTRL_RAMP    1
`define VSP_CTRL_LEGACY  2
`define VSP_CTRL_LIMFWD  3
`define VSP_CTRL_LIMREV  4
`define VSP_CTRL_ADAPTER 5

// ==========================================
// Reset values and limits
`define VSP_RST_MAXSPD  18'h186a0
`define VSP_RST_BIAS    18'h00000
`define VSP_RST_STEP    18'h00001
`define VSP_FMAX_MAIN   18'h186a0
`define VSP_FMAX_ADAPT  18'h30d40

// ==========================================
// Timing
`define VSP_CLK_NS      4
`define VSP_TICK_NS     1000
`define VSP_TICK_CYC    ((`VSP_TICK_NS + `VSP_CLK_NS - 1) / `VSP_CLK_NS)
`define VSP_HALF_CLK_HZ 28'h7735940

`endif

// ===== src/vsp_pkg.sv
// vsp_pkg: types shared by the pulse output channel
// Assumes nothing beyond a SystemVerilog compiler.
package vsp_pkg;

	// ==========================================
	// Types
	typedef enum logic [1:0] {
		VSP_IDLE,
		VSP_RUN,
		VSP_DECEL
	} vsp_state_e;

	typedef enum logic [1:0] {
		VSP_CAUSE_NONE,
		VSP_CAUSE_ZERO,
		VSP_CAUSE_RELEASE
	} vsp_cause_e;

endpackage

// ===== src/vsp_pulse_gen.sv
// vsp_pulse_gen: phase accumulator dividing aclk down to the pulse rate
// Assumes aclk at 250 MHz; rate is in Hz and may change at any cycle.
`timescale 1ns/1ps
`include "vsp_consts.svh"

module vsp_pulse_gen (
	input  wire logic        aclk,    // System clock
	input  wire logic        aresetn, // Sync reset, active low
	input  wire logic        run,     // Train allowed
	input  wire logic [17:0] rate,    // Pulse rate in Hz
	output logic             pulse_r, // Pulse line
	output logic             rise_r   // One cycle per pulse
);

	logic [27:0] acc_r;
	logic [27:0] sum;
	logic        wrap;
	logic [27:0] acc_nxt;

	// ==========================================
	// Accumulator
	// Toggle at twice the rate so one full period per Hz
	assign sum     = acc_r + {10'h000, rate};
	assign wrap    = sum >= `VSP_HALF_CLK_HZ;
	assign acc_nxt = !run ? 28'h0000000 : (wrap ? sum - `VSP_HALF_CLK_HZ : sum);

	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			acc_r   <= 28'h0000000;
			pulse_r <= 1'b0;
			rise_r  <= 1'b0;
		end else begin
			acc_r   <= acc_nxt; // R16
			pulse_r <= run & (wrap ? ~pulse_r : pulse_r);
			rise_r  <= run & wrap & ~pulse_r;
		end
	end

endmodule

// ===== src/vsp_top.sv
// vsp_top: variable-speed pulse output channel with AXI4-Lite registers
// Assumes one 250 MHz clock, sync active-low reset, a lite master
// with at most one write and one read outstanding.
//
// Added by the designer: the AXI4-Lite slave port and the placing of the registers.
`timescale 1ns/1ps
`include "vsp_consts.svh"

module vsp_top (
	input  wire logic        aclk,      // System clock
	input  wire logic        aresetn,   // Sync reset, active low
	input  wire logic [7:0]  awaddr,    // Write address
	input  wire logic        awvalid,   // Write address valid
	output logic             awready,   // Write address ready
	input  wire logic [31:0] wdata,     // Write data
	input  wire logic [3:0]  wstrb,     // Write strobes
	input  wire logic        wvalid,    // Write data valid
	output logic             wready,    // Write data ready
	output logic [1:0]       bresp,     // Write response
	output logic             bvalid,    // Write response valid
	input  wire logic        bready,    // Write response ready
	input  wire logic [7:0]  araddr,    // Read address
	input  wire logic        arvalid,   // Read address valid
	output logic             arready,   // Read address ready
	output logic [31:0]      rdata,     // Read data
	output logic [1:0]       rresp,     // Read response
	output logic             rvalid,    // Read data valid
	input  wire logic        rready,    // Read data ready
	output logic             pulse_out, // Pulse line to amplifier
	output logic             dir_out,   // Direction line, high forward
	output logic             busy_out,  // Pulse output busy
	output logic             cmd_grant, // Other command accepted
	output logic             irq        // Level interrupt
);

	// ==========================================
	// Functions
	function automatic logic [17:0] vsp_clamp(input logic [31:0] v,
			input logic [17:0] lim);
		vsp_clamp = (v > {14'h0000, lim}) ? lim : v[17:0];
	endfunction

	// Linear move toward tgt by at most stp
	function automatic logic [17:0] vsp_step(input logic [17:0] cur,
			input logic [17:0] tgt, input logic [17:0] stp);
		if (cur < tgt) begin
			vsp_step = (tgt - cur > stp) ? cur + stp : tgt;
		end else begin
			vsp_step = (cur - tgt > stp) ? cur - stp : tgt;
		end
	endfunction

	function automatic logic [31:0] vsp_wmask(input logic [31:0] old,
			input logic [31:0] nw, input logic [3:0] strb);
		logic [31:0] m;
		m = {{8{strb[3]}}, {8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
		vsp_wmask = (old & ~m) | (nw & m);
	endfunction

	// ==========================================
	// Declarations
	logic [5:0]        ctrl_r;
	logic [31:0]       freq_r;
	logic [17:0]       bias_r;
	logic [17:0]       max_r;
	logic [17:0]       step_r;
	logic [3:0]        ist_r;
	logic [3:0]        imask_r;
	logic [31:0]       pos_r;
	logic [7:0]        tick_r;

	vsp_pkg::vsp_state_e state_r;
	vsp_pkg::vsp_state_e state_nxt;
	vsp_pkg::vsp_cause_e cause_r;
	vsp_pkg::vsp_cause_e cause_nxt;

	logic [17:0]       rate_r;
	logic [17:0]       rate_nxt;
	logic              dir_r;
	logic              dir_nxt;
	logic              busy_r;
	logic              busy_nxt;
	logic              done_r;
	logic              abn_r;
	logic              fin;
	logic              fin_abn;
	logic              started;
	logic              rise;

	logic              aw_have_r;
	logic              w_have_r;
	logic [7:0]        awaddr_q;
	logic [31:0]       wdata_q;
	logic [3:0]        wstrb_q;

	// ==========================================
	// Control decode
	wire        act       = ctrl_r[`VSP_CTRL_ACT];
	// One enable for the whole channel set; no per-line choice
	wire        ramp_en   = ctrl_r[`VSP_CTRL_RAMP] & ~ctrl_r[`VSP_CTRL_LEGACY]; // R12 R13
	wire        lim_fwd   = ctrl_r[`VSP_CTRL_LIMFWD];
	wire        lim_rev   = ctrl_r[`VSP_CTRL_LIMREV];
	wire [17:0] fmax_hw   = ctrl_r[`VSP_CTRL_ADAPTER] ? `VSP_FMAX_ADAPT : `VSP_FMAX_MAIN;
	wire [17:0] fmax      = (max_r < fmax_hw) ? max_r : fmax_hw;
	wire        freq_neg  = freq_r[31];
	wire [31:0] freq_abs  = freq_neg ? (~freq_r + 32'h00000001) : freq_r;
	wire [17:0] target    = vsp_clamp(freq_abs, fmax); // R14 R17
	wire [17:0] start_rt  = vsp_clamp({14'h0000, bias_r}, target);
	wire        start_lim = freq_neg ? lim_rev : lim_fwd;
	wire        lim_hit   = dir_r ? lim_fwd : lim_rev;
	wire        tick      = tick_r == 8'(`VSP_TICK_CYC - 1);
	wire        start_ok  = act & (target != 18'h00000) & ~start_lim;

	// ==========================================
	// Write channel
	wire        aw_fire  = awvalid & awready;
	wire        w_fire   = wvalid & wready;
	wire        have_aw  = aw_have_r | aw_fire;
	wire        have_w   = w_have_r | w_fire;
	wire        wr_go    = have_aw & have_w & ~bvalid;
	wire [7:0]  wa       = aw_have_r ? awaddr_q : awaddr;
	wire [31:0] wd       = w_have_r ? wdata_q : wdata;
	wire [3:0]  ws       = w_have_r ? wstrb_q : wstrb;
	wire        aw_h_nxt = have_aw & ~wr_go;
	wire        w_h_nxt  = have_w & ~wr_go;
	wire        bv_nxt   = wr_go | (bvalid & ~bready);

	wire        wr_ctrl  = wr_go & (wa[7:2] == `VSP_OFF_CTRL >> 2);
	wire        wr_freq  = wr_go & (wa[7:2] == `VSP_OFF_FREQ >> 2);
	wire        wr_ist   = wr_go & (wa[7:2] == `VSP_OFF_ISTAT >> 2);
	wire        wr_imask = wr_go & (wa[7:2] == `VSP_OFF_IMASK >> 2);
	wire        wr_bias  = wr_go & (wa[7:2] == `VSP_OFF_BIAS >> 2);
	wire        wr_max   = wr_go & (wa[7:2] == `VSP_OFF_MAXSPD >> 2);
	wire        wr_step  = wr_go & (wa[7:2] == `VSP_OFF_STEP >> 2);
	wire        wr_cmd   = wr_go & (wa[7:2] == `VSP_OFF_CMD >> 2);
	wire        wr_stat  = wr_go & (wa[7:2] == `VSP_OFF_STAT >> 2);
	wire        wr_pos   = wr_go & (wa[7:2] == `VSP_OFF_POS >> 2);
	wire        wr_hit   = wr_ctrl | wr_freq | wr_ist | wr_imask | wr_bias |
	                       wr_max | wr_step | wr_cmd | wr_stat | wr_pos;

	wire [31:0] ctrl_w   = vsp_wmask({26'h0000000, ctrl_r}, wd, ws);
	wire [31:0] bias_w   = vsp_wmask({14'h0000, bias_r}, wd, ws);
	wire [31:0] max_w    = vsp_wmask({14'h0000, max_r}, wd, ws);
	wire [31:0] step_w   = vsp_wmask({14'h0000, step_r}, wd, ws);

	// ==========================================
	// Other command gate and events
	wire        cmd_req  = wr_cmd & ws[0] & wd[0];
	wire        refused  = cmd_req & busy_r; // R09
	wire        ev_done  = fin & ~fin_abn & (cause_nxt != vsp_pkg::VSP_CAUSE_RELEASE);
	wire [3:0]  ev       = {refused, fin, fin & fin_abn, ev_done};
	wire [3:0]  ist_clr  = wr_ist & ws[0] ? wd[3:0] : 4'h0;
	// Set beats clear when both land together
	wire [3:0]  ist_nxt  = (ist_r & ~ist_clr) | ev;

	// ==========================================
	// Read channel
	wire        rd_go    = arvalid & arready;
	wire        rv_nxt   = rd_go | (rvalid & ~rready);
	wire [5:0]  ra       = araddr[7:2];
	wire [31:0] stat_w   = {24'h000000, cause_r, state_r, dir_r, abn_r, done_r, busy_r};
	wire        rd_hit   = (ra <= (`VSP_OFF_CMD >> 2));
	wire [31:0] rd_data  =
		(ra == `VSP_OFF_CTRL >> 2)   ? {26'h0000000, ctrl_r} :
		(ra == `VSP_OFF_FREQ >> 2)   ? freq_r :
		(ra == `VSP_OFF_STAT >> 2)   ? stat_w :
		(ra == `VSP_OFF_ISTAT >> 2)  ? {28'h0000000, ist_r} :
		(ra == `VSP_OFF_IMASK >> 2)  ? {28'h0000000, imask_r} :
		(ra == `VSP_OFF_BIAS >> 2)   ? {14'h0000, bias_r} :
		(ra == `VSP_OFF_MAXSPD >> 2) ? {14'h0000, max_r} :
		(ra == `VSP_OFF_STEP >> 2)   ? {14'h0000, step_r} :
		(ra == `VSP_OFF_POS >> 2)    ? pos_r :
		32'h00000000;

	// ==========================================
	// Channel sequence
	always_comb begin
		state_nxt = state_r;
		cause_nxt = cause_r;
		rate_nxt  = rate_r;
		dir_nxt   = dir_r;
		busy_nxt  = busy_r;
		fin       = 1'b0;
		fin_abn   = 1'b0;
		started   = 1'b0;
		unique case (state_r)
			vsp_pkg::VSP_IDLE: begin
				if (start_ok) begin
					started   = 1'b1;
					state_nxt = vsp_pkg::VSP_RUN;
					cause_nxt = vsp_pkg::VSP_CAUSE_NONE;
					busy_nxt  = 1'b1; // R16
					dir_nxt   = ~freq_neg; // R15
					rate_nxt  = ramp_en ? start_rt : target; // R13 R17
				end
			end
			vsp_pkg::VSP_RUN: begin
				if (lim_hit) begin
					fin     = 1'b1; // R08
					fin_abn = 1'b1;
				end else if (!act) begin
					cause_nxt = vsp_pkg::VSP_CAUSE_RELEASE;
					if (ramp_en) begin
						state_nxt = vsp_pkg::VSP_DECEL; // R05
					end else begin
						fin = 1'b1; // R06
					end
				end else if (target == 18'h00000) begin
					cause_nxt = vsp_pkg::VSP_CAUSE_ZERO;
					if (ramp_en) begin
						state_nxt = vsp_pkg::VSP_DECEL; // R01
					end else begin
						fin = 1'b1; // R02
					end
				end else if (!ramp_en) begin
					rate_nxt = target;
				end else if (tick) begin
					rate_nxt = vsp_step(rate_r, target, step_r); // R17
				end
			end
			vsp_pkg::VSP_DECEL: begin
				if (lim_hit) begin
					fin     = 1'b1; // R08
					fin_abn = 1'b1;
				end else if (!ramp_en || rate_r <= bias_r) begin
					fin = 1'b1; // R01 R05
				end else if (tick) begin
					rate_nxt = vsp_step(rate_r, bias_r, step_r); // R17
				end
			end
			default: begin
				state_nxt = vsp_pkg::VSP_IDLE;
			end
		endcase
		if (fin) begin
			state_nxt = vsp_pkg::VSP_IDLE;
			rate_nxt  = 18'h00000;
			dir_nxt   = 1'b0; // R11
			busy_nxt  = 1'b0; // R16
		end
	end

	// ==========================================
	// Pulse divider
	vsp_pulse_gen u_gen (
		.aclk    (aclk),
		.aresetn (aresetn),
		// Next state gates the train: no last edge leaves as direction drops
		.run     (state_nxt != vsp_pkg::VSP_IDLE),
		.rate    (rate_r),
		.pulse_r (pulse_out),
		.rise_r  (rise)
	);

	// ==========================================
	// Channel state registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			state_r <= vsp_pkg::VSP_IDLE;
			cause_r <= vsp_pkg::VSP_CAUSE_NONE;
			rate_r  <= 18'h00000;
			dir_r   <= 1'b0;
			busy_r  <= 1'b0;
			tick_r  <= 8'h00;
		end else begin
			state_r <= state_nxt;
			cause_r <= cause_nxt;
			rate_r  <= rate_nxt;
			dir_r   <= dir_nxt;
			busy_r  <= busy_nxt;
			tick_r  <= tick ? 8'h00 : tick_r + 8'h01;
		end
	end

	// Flags describe the last run; cleared when a new one starts
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			done_r <= 1'b0;
			abn_r  <= 1'b0;
			pos_r  <= 32'h00000000;
		end else begin
			done_r <= started ? 1'b0 : (done_r | ev_done); // R07
			abn_r  <= started ? 1'b0 : (abn_r | (fin & fin_abn)); // R08
			if (rise) begin
				pos_r <= dir_r ? pos_r + 32'h00000001 : pos_r - 32'h00000001; // R15
			end
		end
	end

	// ==========================================
	// Software registers
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			ctrl_r  <= 6'h00;
			freq_r  <= 32'h00000000;
			bias_r  <= `VSP_RST_BIAS;
			max_r   <= `VSP_RST_MAXSPD;
			step_r  <= `VSP_RST_STEP;
			imask_r <= 4'h0;
			ist_r   <= 4'h0;
		end else begin
			if (wr_ctrl) ctrl_r <= ctrl_w[5:0];
			if (wr_freq) freq_r <= vsp_wmask(freq_r, wd, ws);
			if (wr_bias) bias_r <= bias_w[17:0];
			if (wr_max) max_r <= max_w[17:0];
			if (wr_step) step_r <= step_w[17:0];
			if (wr_imask && ws[0]) imask_r <= wd[3:0];
			ist_r <= ist_nxt;
		end
	end

	// ==========================================
	// Outputs
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			dir_out   <= 1'b0;
			busy_out  <= 1'b0;
			cmd_grant <= 1'b0;
			irq       <= 1'b0;
		end else begin
			dir_out   <= dir_nxt;
			busy_out  <= busy_nxt;
			cmd_grant <= cmd_req & ~busy_r; // R09
			irq       <= |(ist_nxt & imask_r);
		end
	end

	// ==========================================
	// AXI4-Lite handshake
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			aw_have_r <= 1'b0;
			w_have_r  <= 1'b0;
			awaddr_q  <= 8'h00;
			wdata_q   <= 32'h00000000;
			wstrb_q   <= 4'h0;
			awready   <= 1'b0;
			wready    <= 1'b0;
			bvalid    <= 1'b0;
			bresp     <= 2'h0;
		end else begin
			aw_have_r <= aw_h_nxt;
			w_have_r  <= w_h_nxt;
			if (aw_fire) awaddr_q <= awaddr;
			if (w_fire) begin
				wdata_q <= wdata;
				wstrb_q <= wstrb;
			end
			awready <= ~aw_h_nxt & ~bv_nxt;
			wready  <= ~w_h_nxt & ~bv_nxt;
			bvalid  <= bv_nxt;
			if (wr_go) bresp <= wr_hit ? 2'h0 : 2'h2;
		end
	end

	// Unmapped reads answer slave error with zero data
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready <= 1'b0;
			rvalid  <= 1'b0;
			rdata   <= 32'h00000000;
			rresp   <= 2'h0;
		end else begin
			arready <= ~rv_nxt;
			rvalid  <= rv_nxt;
			if (rd_go) begin
				rdata <= rd_data;
				rresp <= rd_hit ? 2'h0 : 2'h2;
			end
		end
	end

endmodule

// ===== test/vsp_servo_model.sv
// vsp_servo_model: amplifier end of the pulse and direction lines
// Assumes both lines come from the aclk domain.
`timescale 1ns/1ps
module vsp_servo_model #(
	parameter int QUIET = 32'h1f4 // Quiet cycles meaning standstill
) (
	input  wire logic        aclk,     // Clock
	input  wire logic        aresetn,  // Reset, active low
	input  wire logic        pulse_in, // Pulse line
	input  wire logic        dir_in,   // High forward
	output logic [31:0]      pos_r,    // Position count
	output logic             ready_r   // Motor at rest
);
	logic        pulse_d_r;
	logic [15:0] quiet_r;
	wire         step = pulse_in && !pulse_d_r;
	// ==========
	// Counting
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			pulse_d_r <= 1'b0;
			pos_r     <= '0;
			quiet_r   <= '0;
			ready_r   <= 1'b0;
		end else begin
			pulse_d_r <= pulse_in;
			if (step)
				pos_r <= dir_in ? pos_r + 32'h1 : pos_r - 32'h1;
			quiet_r <= step ? 16'h0 : quiet_r + {15'h0, quiet_r != QUIET[15:0]};
			// Standstill after a full quiet spell, which a slow pulse train also leaves between pulses
			ready_r <= quiet_r == QUIET[15:0];
		end
	end
endmodule

// ===== test/vsp_assertions.sv
// vsp_assertions: port checks on vsp_top
// Assumes binding into vsp_top; watches its ports only.
`timescale 1ns/1ps
module vsp_assertions (
	input wire logic aclk,      // Clock
	input wire logic aresetn,   // Reset, active low
	input wire logic awvalid,   // Write address valid
	input wire logic awready,   // Write address ready
	input wire logic wvalid,    // Write data valid
	input wire logic wready,    // Write data ready
	input wire logic bvalid,    // Response valid
	input wire logic bready,    // Response ready
	input wire logic arvalid,   // Read address valid
	input wire logic arready,   // Read address ready
	input wire logic rvalid,    // Read data valid
	input wire logic pulse_out, // Pulse line
	input wire logic dir_out,   // Direction line
	input wire logic busy_out,  // Busy
	input wire logic cmd_grant  // Command accepted
);
	default clocking cb @(posedge aclk);
	endclocking
	default disable iff (!aresetn);
	// ==========
	// Register bus
	property p_wr_resp;
		awvalid && awready && wvalid && wready |=> bvalid;
	endproperty
	a_wr_resp: assert property (p_wr_resp) else $error("write not answered");
	property p_wr_hold;
		bvalid |-> !awready && !wready;
	endproperty
	a_wr_hold: assert property (p_wr_hold) else $error("write taken while answering");
	property p_b_drop;
		$fell(bvalid) |-> $past(bready);
	endproperty
	a_b_drop: assert property (p_b_drop) else $error("response dropped early");
	property p_rd_resp;
		arvalid && arready |=> rvalid && !arready;
	endproperty
	a_rd_resp: assert property (p_rd_resp) else $error("read not answered");
	// ==========
	// Pulse lines
	property p_idle_pulse;
		!busy_out [*3] |-> !pulse_out;
	endproperty
	a_idle_pulse: assert property (p_idle_pulse) else $error("pulse while idle");
	property p_pulse_busy;
		$rose(pulse_out) |-> busy_out;
	endproperty
	a_pulse_busy: assert property (p_pulse_busy) else $error("pulse without busy");
	property p_dir_off;
		$fell(busy_out) |-> ##[0:1] !dir_out;
	endproperty
	a_dir_off: assert property (p_dir_off) else $error("direction left on");
	property p_dir_hold;
		busy_out && $past(busy_out) |-> $stable(dir_out);
	endproperty
	a_dir_hold: assert property (p_dir_hold) else $error("direction moved in run");
	property p_grant;
		cmd_grant |-> !$past(busy_out) ##1 !cmd_grant;
	endproperty
	a_grant: assert property (p_grant) else $error("command granted while busy");
endmodule
bind vsp_top vsp_assertions i_chk (.aclk, .aresetn, .awvalid, .awready, .wvalid, .wready, .bvalid, .bready,
	.arvalid, .arready, .rvalid, .pulse_out, .dir_out, .busy_out, .cmd_grant);

// ===== test/testbench.sv
// testbench: drives vsp_top over AXI4-Lite, watches the pulse lines
// Assumes vsp_top, vsp_servo_model and vsp_assertions are compiled.
`timescale 1ns/1ps
`include "vsp_consts.svh"
module testbench;
	logic        aclk = 1'b0, aresetn = 1'b0;
	logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
	logic [31:0] wdata = 32'h0, rdata, pos;
	logic [3:0]  wstrb = 4'hf;
	logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic [1:0]  bresp, rresp;
	logic        awready, wready, bvalid, arready, rvalid, pulse_out, dir_out, busy_out, cmd_grant, irq;
	logic        srv_ready;
	int          err_total = 0, total_checks = 0, grants = 0, cycles = 0;
	always #2 aclk = ~aclk;
	vsp_top i_dut (.aclk, .aresetn, .awaddr, .awvalid, .awready, .wdata, .wstrb, .wvalid, .wready, .bresp,
		.bvalid, .bready, .araddr, .arvalid, .arready, .rdata, .rresp, .rvalid, .rready, .pulse_out,
		.dir_out, .busy_out, .cmd_grant, .irq);
	vsp_servo_model i_srv (.aclk, .aresetn, .pulse_in(pulse_out), .dir_in(dir_out), .pos_r(pos),
		.ready_r(srv_ready));
	// ==========
	// Reporting
	task automatic give_verdict();
		$display("checks %0d errors %0d", total_checks, err_total);
		if (err_total == 0 && total_checks > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
		total_checks++;
		if (got !== exp) begin
			err_total++;
			$display("mismatch at %0t: %s got %h expected %h", $time, what, got, exp);
		end
	endtask
	// Grant pulses last one cycle, so count them as they pass
	always @(posedge aclk) begin
		cycles <= cycles + 1;
		if (cmd_grant === 1'b1)
			grants <= grants + 1;
		if (cycles == 32'hea60) begin
			err_total++;
			give_verdict();
		end
	end
	// ==========
	// Bus cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		do begin
			@(posedge aclk);
			if (awready)
				awvalid <= 1'b0;
			if (wready)
				wvalid <= 1'b0;
		end while (bvalid !== 1'b1);
		bready <= 1'b0;
		chk(32'({bvalid, bresp}), a > 8'h24 ? 32'h6 : 32'h4, "write response");
	endtask
	task automatic rd(input logic [7:0] a, output logic [31:0] d);
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin
			@(posedge aclk);
			if (arready)
				arvalid <= 1'b0;
		end while (rvalid !== 1'b1);
		rready <= 1'b0;
		d = rdata;
		chk(32'({rvalid, rresp}), a > 8'h24 ? 32'h6 : 32'h4, "read response");
	endtask
	task automatic wait_busy(input logic lvl, output int n);
		for (n = 0; n < 4000 && busy_out !== lvl; n++)
			@(posedge aclk);
	endtask
	// ==========
	// One run: start, refused command, stop by zero, release or limit
	task automatic trial(input logic [31:0] ctrl, input logic neg, input int how, input logic ramp);
		logic [31:0] f, p0, d;
		int          n, g0;
		f = 32'hea60 + $urandom_range(32'h9c40);
		for (n = 0; n < 2000 && srv_ready !== 1'b1; n++)
			@(posedge aclk);
		wr(`VSP_OFF_ISTAT, 32'hf);
		wr(`VSP_OFF_CTRL, ctrl);
		wr(`VSP_OFF_FREQ, neg ? -f : f);
		wait_busy(1'b1, n);
		chk(32'(dir_out), 32'(!neg), "direction");
		p0 = pos;
		for (n = 0; n < 30000 && pos === p0; n++)
			@(posedge aclk);
		chk(pos - p0, neg ? 32'hffffffff : 32'h1, "count step");
		g0 = grants;
		wr(`VSP_OFF_CMD, 32'h1);
		@(posedge aclk);
		chk(grants, g0, "busy command");
		case (how)
			0: wr(`VSP_OFF_FREQ, 32'h0);
			1: wr(`VSP_OFF_CTRL, ctrl & ~32'h1);
			default: wr(`VSP_OFF_CTRL, ctrl | (neg ? 32'h10 : 32'h8));
		endcase
		wait_busy(1'b0, n);
		chk(32'(n > 100), 32'(ramp), "ramp on stop");
		chk(32'(dir_out), 32'h0, "direction at end");
		rd(`VSP_OFF_STAT, d);
		chk(d & 32'h7, how == 0 ? 32'h2 : how == 1 ? 32'h0 : 32'h4, "end flags");
		rd(`VSP_OFF_ISTAT, d);
		chk(d & 32'hf, how == 0 ? 32'hd : how == 1 ? 32'hc : 32'he, "events");
		chk(32'(irq), 32'(how != 1), "interrupt");
		wr(`VSP_OFF_ISTAT, 32'hf);
		repeat (2) @(posedge aclk);
		chk(32'(irq), 32'h0, "interrupt cleared");
		rd(`VSP_OFF_POS, d);
		chk(d, pos, "position");
		g0 = grants;
		wr(`VSP_OFF_CMD, 32'h1);
		@(posedge aclk);
		chk(grants, g0 + 1, "idle command");
		if (how != 0)
			wr(`VSP_OFF_FREQ, 32'h0);
	endtask
	// ==========
	// Main sequence
	initial begin
		logic [31:0] d;
		void'($urandom(32'h9434));
		repeat (8) @(posedge aclk);
		aresetn <= 1'b1;
		rd(`VSP_OFF_BIAS, d);
		chk(d, 32'h0, "bias at reset");
		rd(`VSP_OFF_MAXSPD, d);
		chk(d, 32'h186a0, "max at reset");
		rd(`VSP_OFF_STEP, d);
		chk(d, 32'h1, "step at reset");
		rd(8'h40, d);
		chk(d, 32'h0, "unmapped read");
		wr(8'h40, 32'h5);
		wr(`VSP_OFF_BIAS, 32'h2710);
		wr(`VSP_OFF_STEP, 32'h4e20);
		wr(`VSP_OFF_IMASK, 32'h3);
		trial(32'h1, 1'b0, 0, 1'b0);
		trial(32'h3, 1'b0, 0, 1'b1);
		trial(32'h27, 1'b1, 0, 1'b0);
		trial(32'h3, 1'b1, 1, 1'b1);
		trial(32'h1, 1'b0, 1, 1'b0);
		trial(32'h3, 1'b0, 2, 1'b0);
		trial(32'h1, 1'b1, 2, 1'b0);
		give_verdict();
	end
endmodule
